// *** include/ppdec_pkg.sv ***
// Constants for the port input and power-off enable decode block
package ppdec_pkg;
  localparam int unsigned INSTR_W = 10;
  localparam int unsigned ACC_W = 4;
  localparam int unsigned PORT_W = 4;
  localparam int unsigned PORT_TWO_W = 2;

  localparam logic [INSTR_W-1:0] OPC_ARM_POWER_OFF = 10'h05B;
  localparam logic [INSTR_W-1:0] OPC_SINGLE_BIT = 10'h26F;
  localparam logic [INSTR_W-1:0] OPC_PORT_ZERO = 10'h260;
  localparam logic [INSTR_W-1:0] OPC_PORT_TWO = 10'h262;
  // Defaults for codes that are not fixed here; overridable at the top
  localparam logic [INSTR_W-1:0] OPC_PORT_ONE_DFLT = 10'h261;
  localparam logic [INSTR_W-1:0] OPC_POWER_OFF_DFLT = 10'h3FE;

  // Positions in the one-hot decode vector
  localparam int unsigned OP_N = 6;
  localparam int unsigned OP_ARM = 0;
  localparam int unsigned OP_PWROFF = 1;
  localparam int unsigned OP_SBIT = 2;
  localparam int unsigned OP_P0 = 3;
  localparam int unsigned OP_P1 = 4;
  localparam int unsigned OP_P2 = 5;

  localparam logic [ACC_W-1:0] ACC_RST = 4'h0;
  localparam logic CARRY_RST = 1'b0;

  typedef enum logic [1:0] {
    PP_IDLE = 2'b01,
    PP_ARMED = 2'b10
  } ppdec_arm_e;
endpackage : ppdec_pkg

// *** verif/ppdec_bench.sv ***
// Self-checking bench for the port input and power-off decode block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ppdec_bench;
  logic core_clk = 0, rst = 1, instr_valid = 0, acc_wr_en = 0, carry_wr_en = 0;
  logic carry_wr_data = 0, kbit, cf, gh, go, ign, armed, skip;
  logic [9:0] instr_code = 0;
  logic [3:0] acc_wr_data = 0, pat = 0, p0, p1, acc_q;
  logic [1:0] p2;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #25 core_clk = ~core_clk;
  ppdec_port_model pm (.pat(pat), .kbit(kbit), .p0(p0), .p1(p1), .p2(p2));
  ppdec_top dut (.core_clk(core_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_code(instr_code), .load_acc_from_single_bit_port_in(kbit), .input_port_zero(p0),
    .input_port_one(p1), .input_port_two(p2), .acc_wr_en(acc_wr_en), .acc_wr_data(acc_wr_data),
    .carry_wr_en(carry_wr_en), .carry_wr_data(carry_wr_data), .acc_q(acc_q), .carry_flag_q(cf),
    .group_hit_q(gh), .power_off_go_q(go), .power_off_ignored_q(ign),
    .power_off_armed_q(armed), .skip_next_q(skip));
  task automatic end_of_test();
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic issue(input logic v, input logic [9:0] c);
    @(negedge core_clk);
    instr_valid = v;
    instr_code = c;
  endtask : issue
  // Back-to-back loads while the rest of the core fights for acc and carry
  task automatic run_loads();
    logic [9:0] ops [4] = '{ppdec_pkg::OPC_PORT_ZERO, ppdec_pkg::OPC_SINGLE_BIT,
      ppdec_pkg::OPC_PORT_ONE_DFLT, ppdec_pkg::OPC_PORT_TWO};
    carry_wr_en = 1;
    carry_wr_data = 1;
    for (int i = 0; i < 8; i++) begin
      issue(1'b1, ops[i % 4]);
      pat = 4'(i * 5 + 10);
      carry_wr_data = 0;
      acc_wr_en = 1;
      acc_wr_data = 4'hF;
      @(posedge core_clk);
      #1;
      case (i % 4)
        0: `CHK("acc port zero", pat, acc_q)
        1: `CHK("acc single bit", {3'h0, pat[3]}, acc_q)
        2: `CHK("acc port one", ~pat, acc_q)
        default: `CHK("acc port two", {2'h0, pat[1:0]}, acc_q)
      endcase
      `CHK("carry hit skip", 3'h6, {cf, gh, skip})
    end
    issue(1'b0, 10'h000);
    @(posedge core_clk);
    #1;
    `CHK("core writes", 5'h1E, {acc_q, cf})
    acc_wr_en = 0;
    carry_wr_en = 0;
  endtask : run_loads
  // mid: 0 none, 1 idle cycle, 2 other instruction between
  task automatic power(input logic [9:0] first, input int mid, input logic exp_go);
    issue(1'b1, first);
    if (mid > 0) issue(mid == 2, 10'h000);
    issue(1'b1, ppdec_pkg::OPC_POWER_OFF_DFLT);
    `CHK("armed level", exp_go, armed)
    @(posedge core_clk);
    #1;
    `CHK("power off", {exp_go, !exp_go}, {go, ign})
    issue(1'b0, 10'h000);
  endtask : power
  initial begin
    repeat (10) @(negedge core_clk);
    rst = 0;
    `CHK("after reset", 8'h00, {acc_q, cf, gh, go, skip})
    run_loads();
    power(ppdec_pkg::OPC_ARM_POWER_OFF, 0, 1'b1);
    power(10'h000, 0, 1'b0);
    power(ppdec_pkg::OPC_ARM_POWER_OFF, 1, 1'b1);
    power(ppdec_pkg::OPC_ARM_POWER_OFF, 2, 1'b0);
    end_of_test();
  end
  // Whole run is well under 100 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      end_of_test();
    end
  end
endmodule : ppdec_bench
`default_nettype wire

// *** verif/ppdec_port_model.sv ***
// Input port pins seen by the core, all derived from one pattern
`timescale 1ns/1ps
`default_nettype none
module ppdec_port_model (
  input wire logic [3:0] pat,
  output logic kbit,
  output logic [3:0] p0,
  output logic [3:0] p1,
  output logic [1:0] p2
);
  // Port one is the inverse so a swapped port select shows at once
  assign kbit = pat[3];
  assign p0 = pat;
  assign p1 = ~pat;
  assign p2 = pat[1:0];
endmodule : ppdec_port_model
`default_nettype wire

// *** verif/ppdec_top_monitor.sv ***
// Assertion checker for the port input and power-off decode block
`timescale 1ns/1ps
`default_nettype none
module ppdec_top_monitor #(
  parameter logic [9:0] OPC_PORT_ONE = 10'h261,
  parameter logic [9:0] OPC_POWER_OFF = 10'h3FE
) (
  input wire logic core_clk, rst, instr_valid, load_acc_from_single_bit_port_in,
  input wire logic [9:0] instr_code,
  input wire logic [3:0] input_port_zero, input_port_one, acc_q,
  input wire logic [1:0] input_port_two,
  input wire logic carry_flag_q, power_off_go_q, power_off_armed_q, skip_next_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic sb = instr_valid && instr_code == ppdec_pkg::OPC_SINGLE_BIT;
  wire logic z = instr_valid && instr_code == ppdec_pkg::OPC_PORT_ZERO;
  wire logic o = instr_valid && instr_code == OPC_PORT_ONE;
  wire logic t = instr_valid && instr_code == ppdec_pkg::OPC_PORT_TWO;
  wire logic a = instr_valid && instr_code == ppdec_pkg::OPC_ARM_POWER_OFF;
  wire logic pf = instr_valid && instr_code == OPC_POWER_OFF;
  wire logic grp = sb || z || o || t || a || pf;
  AST_SBIT_LOW: assert property (sb |=> acc_q[0] == $past(load_acc_from_single_bit_port_in))
    else $error("single-bit load wrong");
  AST_SBIT_HIGH: assert property (sb |=> acc_q[3:1] == 3'h0) else $error("bits 3-1 not cleared");
  AST_PORT_ZERO: assert property (z |=> acc_q == $past(input_port_zero))
    else $error("port zero load wrong");
  AST_PORT_ONE: assert property (o |=> acc_q == $past(input_port_one))
    else $error("port one load wrong");
  AST_PORT_TWO_LOW: assert property (t |=> acc_q[1:0] == $past(input_port_two))
    else $error("port two load wrong");
  AST_PORT_TWO_HIGH: assert property (t |=> acc_q[3:2] == 2'h0) else $error("bits 3-2 not zero");
  AST_ARMED_GO: assert property (a ##1 pf |=> power_off_go_q) else $error("armed power-off lost");
  AST_UNARMED: assert property (pf && !power_off_armed_q |=> !power_off_go_q)
    else $error("unarmed power-off taken");
  AST_CARRY_KEPT: assert property (grp |=> $stable(carry_flag_q)) else $error("carry changed");
  AST_NO_SKIP: assert property (grp |=> !skip_next_q) else $error("skip raised");
  cover property (a ##1 pf);
  cover property (pf && !power_off_armed_q);
  cover property (z ##1 sb ##1 o ##1 t);
endmodule : ppdec_top_monitor
bind ppdec_top ppdec_top_monitor #(.OPC_PORT_ONE(OPC_PORT_ONE),
  .OPC_POWER_OFF(OPC_POWER_OFF)) u_mon (.*);
`default_nettype wire

// *** verilog/ppdec_opdec.sv ***
// One-hot opcode decoder for the port input and power-off enable group
`timescale 1ns/1ps
`default_nettype none
module ppdec_opdec #(
  parameter logic [ppdec_pkg::INSTR_W-1:0] OPC_PORT_ONE = ppdec_pkg::OPC_PORT_ONE_DFLT,
  parameter logic [ppdec_pkg::INSTR_W-1:0] OPC_POWER_OFF = ppdec_pkg::OPC_POWER_OFF_DFLT
) (
  input wire logic [ppdec_pkg::INSTR_W-1:0] instr_code,
  output logic [ppdec_pkg::OP_N-1:0] op_sel
);
  logic [ppdec_pkg::INSTR_W-1:0] opc_tab [ppdec_pkg::OP_N];

  assign opc_tab[ppdec_pkg::OP_ARM] = ppdec_pkg::OPC_ARM_POWER_OFF;
  assign opc_tab[ppdec_pkg::OP_PWROFF] = OPC_POWER_OFF;
  assign opc_tab[ppdec_pkg::OP_SBIT] = ppdec_pkg::OPC_SINGLE_BIT;
  assign opc_tab[ppdec_pkg::OP_P0] = ppdec_pkg::OPC_PORT_ZERO;
  assign opc_tab[ppdec_pkg::OP_P1] = OPC_PORT_ONE;
  assign opc_tab[ppdec_pkg::OP_P2] = ppdec_pkg::OPC_PORT_TWO;

  // Full 10-bit compare; no don't-care bits in this group
  for (genvar i = 0; i < ppdec_pkg::OP_N; i++) begin : g_cmp
    assign op_sel[i] = (instr_code == opc_tab[i]);
  end
endmodule : ppdec_opdec
`default_nettype wire

// *** verilog/ppdec_top.sv ***
// Execute stage for the port input and power-off enable instruction group
//
// Function
// - The arming opcode makes a power-off instruction that comes right after it take effect.
// - The single-bit port opcode copies the one-bit port level into accumulator bit 0.
// - The single-bit port opcode clears accumulator bits 3 to 1.
// - The port zero opcode loads all four accumulator bits from port zero.
// - The port one opcode loads all four accumulator bits from port one.
// - The port two opcode copies port two pins 1 and 0 into accumulator bits 1 and 0.
// - The port two opcode forces accumulator bits 3 and 2 to zero.
`timescale 1ns/1ps
`default_nettype none
module ppdec_top #(
  parameter logic [ppdec_pkg::INSTR_W-1:0] OPC_PORT_ONE = ppdec_pkg::OPC_PORT_ONE_DFLT,
  parameter logic [ppdec_pkg::INSTR_W-1:0] OPC_POWER_OFF = ppdec_pkg::OPC_POWER_OFF_DFLT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [ppdec_pkg::INSTR_W-1:0] instr_code,
  input wire logic load_acc_from_single_bit_port_in,
  input wire logic [ppdec_pkg::PORT_W-1:0] input_port_zero,
  input wire logic [ppdec_pkg::PORT_W-1:0] input_port_one,
  input wire logic [ppdec_pkg::PORT_TWO_W-1:0] input_port_two,
  input wire logic acc_wr_en,
  input wire logic [ppdec_pkg::ACC_W-1:0] acc_wr_data,
  input wire logic carry_wr_en,
  input wire logic carry_wr_data,
  output logic [ppdec_pkg::ACC_W-1:0] acc_q,
  output logic carry_flag_q,
  output logic group_hit_q,
  output logic power_off_go_q,
  output logic power_off_ignored_q,
  output logic power_off_armed_q,
  output logic skip_next_q
);
  logic [ppdec_pkg::OP_N-1:0] op_sel;
  logic [ppdec_pkg::OP_N-1:0] op_exec;
  logic group_op;
  logic [ppdec_pkg::ACC_W-1:0] acc_d;
  ppdec_pkg::ppdec_arm_e arm_q;
  ppdec_pkg::ppdec_arm_e arm_d;

  ppdec_opdec #(
    .OPC_PORT_ONE(OPC_PORT_ONE),
    .OPC_POWER_OFF(OPC_POWER_OFF)
  ) u_opdec (
    .instr_code(instr_code),
    .op_sel(op_sel)
  );

  assign op_exec = instr_valid ? op_sel : '0;
  // Arm and power-off count as group members so the core sees them as handled
  assign group_op = |op_exec;

  // Accumulator next value; group loads win over the rest of the core
  always_comb begin
    acc_d = acc_q;
    if (op_exec[ppdec_pkg::OP_SBIT]) begin
      acc_d = {3'h0, load_acc_from_single_bit_port_in};
    end else if (op_exec[ppdec_pkg::OP_P0]) begin
      acc_d = input_port_zero;
    end else if (op_exec[ppdec_pkg::OP_P1]) begin
      acc_d = input_port_one;
    end else if (op_exec[ppdec_pkg::OP_P2]) begin
      acc_d = {2'h0, input_port_two};
    end else if (acc_wr_en && !group_op) begin
      acc_d = acc_wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q <= ppdec_pkg::ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Carry is never written by this group; an external write in the same cycle is ignored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carry_flag_q <= ppdec_pkg::CARRY_RST;
    end else if (carry_wr_en && !group_op) begin
      carry_flag_q <= carry_wr_data;
    end
  end

  // Arming only reaches the very next executed instruction; another arm opcode there keeps it armed
  always_comb begin
    arm_d = arm_q;
    case (arm_q)
      ppdec_pkg::PP_IDLE: begin
        if (op_exec[ppdec_pkg::OP_ARM]) begin
          arm_d = ppdec_pkg::PP_ARMED;
        end
      end
      ppdec_pkg::PP_ARMED: begin
        if (instr_valid && !op_exec[ppdec_pkg::OP_ARM]) begin
          arm_d = ppdec_pkg::PP_IDLE;
        end
      end
      default: begin
        arm_d = ppdec_pkg::PP_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arm_q <= ppdec_pkg::PP_IDLE;
    end else begin
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_off_armed_q <= 1'b0;
    end else begin
      power_off_armed_q <= (arm_d == ppdec_pkg::PP_ARMED);
    end
  end

  // Unarmed power-off is flagged, not executed, so a stray code cannot halt the part
  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_off_go_q <= 1'b0;
      power_off_ignored_q <= 1'b0;
    end else begin
      power_off_go_q <= op_exec[ppdec_pkg::OP_PWROFF] && (arm_q == ppdec_pkg::PP_ARMED);
      power_off_ignored_q <= op_exec[ppdec_pkg::OP_PWROFF] && (arm_q != ppdec_pkg::PP_ARMED);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      group_hit_q <= 1'b0;
    end else begin
      group_hit_q <= group_op;
    end
  end

  // Kept as a flop so the skip path timing matches other groups
  always_ff @(posedge core_clk) begin
    if (rst) begin
      skip_next_q <= 1'b0;
    end else begin
      skip_next_q <= 1'b0;
    end
  end
endmodule : ppdec_top
`default_nettype wire
